// >>> verilog/sram_access_params.svh
// Constants of the pipelined burst SRAM access logic.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SRAM_ACCESS_PARAMS_SVH
`define SRAM_ACCESS_PARAMS_SVH

// Array geometry defaults: one word of four nine-bit lanes
`define SA_ADDR_W 20
`define SA_LANES 4
`define SA_LANE_BITS 8
`define SA_LANE_W 9

// Burst counter
`define SA_BURST_W 2
`define SA_BURST_ZERO 2'h0
`define SA_BURST_STEP 2'h1

// Sleep entry and exit time in clock cycles
`define SA_SLEEP_CYCLES 2'h2
`define SA_SLEEP_W 2
`define SA_SLEEP_ZERO 2'h0

// Two-entry write buffer
`define SA_BUF_W 2
`define SA_BUF_EMPTY 2'h0
`define SA_BUF_ONE 2'h1
`define SA_BUF_FULL 2'h2

// Input synchroniser depth for the asynchronous sleep pin
`define SA_SYNC_W 3
`define SA_SYNC_RESET 3'h0

`endif

// >>> verilog/sram_access_pkg.sv
// Types shared by the SRAM access logic.
// Assumes the constants header sits beside it.
`include "sram_access_params.svh"

package sram_access_pkg;

	// Sleep sequencer states, one-hot
	typedef enum logic [3:0] {
		SLP_AWAKE = 4'h1,
		SLP_ENTER = 4'h2,
		SLP_ASLEEP = 4'h4,
		SLP_LEAVE = 4'h8
	} sleep_state_e;

endpackage : sram_access_pkg

// >>> verilog/sram_word_store.sv
// Lane-writable word array with a registered read port.
// Assumes one clock; the read register is the device output register.
`timescale 1ns/1ps
`default_nettype none
`include "sram_access_params.svh"

module sram_word_store #(
	parameter int ADDR_W = `SA_ADDR_W,
	parameter int LANES = `SA_LANES,
	parameter int LANE_W = `SA_LANE_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Write port
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [LANES-1:0] wr_lane,
	input wire logic [LANES*LANE_W-1:0] wr_data,
	// Read port
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [LANES*LANE_W-1:0] rd_data
);

	// ****************************************
	// Lane arrays
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : lane
			logic [LANE_W-1:0] mem [2**ADDR_W];
			logic [LANE_W-1:0] rd_q;

			// Only enabled lanes take the new byte and parity bit
			always_ff @(posedge clk_sys) begin
				if (wr_en && wr_lane[g]) begin
					mem[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
				end
			end

			// Read register holds while not enabled; one register per lane, one driver each
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					rd_q <= '0;
				end else if (rd_en) begin
					rd_q <= mem[rd_addr];
				end
			end
			assign rd_data[g*LANE_W +: LANE_W] = rd_q;
		end
	endgenerate

endmodule : sram_word_store
`default_nettype wire

// >>> verilog/sram_pipe_access.sv
// Synchronous access logic of a pipelined burst SRAM with common data I/O.
// Assumes pins synchronous to clk_sys except sleep_request and output_enable_n.
//
// Operation
// - Register control, address and write data inputs
// - Gate high at edge: hold pipeline state; write buffer still drains to the array
// - Read data leaves through output register
// - Start needs gate low, selects on, load
// - Write strobe high at start means read
// - Drive read data only while enable low
// - Next operation may follow a read directly
// - Deselect three-states outputs after next edge
// - Burst counter gives four accesses per address
// - Strap picks linear or interleaved order
// - Only two low bits change, wrapping
// - Advance steps counter, ignores selects, strobe
// - Access type fixed for whole burst
// - Write strobe low at start means write
// - Drivers off on edge after write issue
// - Write data captured second edge after issue
// - Only selected byte lanes are written
// - Sleep input keeps contents, low power
// - Drivers off first clock after deselect
// - Parity bit follows its byte lane
// - Sleep entry, exit take two cycles
// - Power up deselected, outputs three-stated
`timescale 1ns/1ps
`default_nettype none
`include "sram_access_params.svh"

module sram_pipe_access #(
	parameter int ADDR_W = `SA_ADDR_W,
	parameter int LANES = `SA_LANES,
	parameter int LANE_BITS = `SA_LANE_BITS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Synchronous control pins
	input wire logic clock_gate_n,
	input wire logic chip_select_one_n,
	input wire logic chip_select_two,
	input wire logic chip_select_three_n,
	input wire logic advance_or_load,
	input wire logic write_n,
	input wire logic [LANES-1:0] byte_lane_write_n,
	input wire logic [ADDR_W-1:0] addr,
	// Data and parity lines
	input wire logic [LANES*LANE_BITS-1:0] dq_in,
	input wire logic [LANES-1:0] parity_in,
	output logic [LANES*LANE_BITS-1:0] dq_out,
	output logic [LANES-1:0] parity_out,
	output logic dq_oe,
	// Asynchronous and static pins
	input wire logic output_enable_n,
	input wire logic burst_order,
	input wire logic sleep_request,
	// Status
	output logic sleep_active
);

	// ****************************************
	// State
	// ****************************************
	localparam int LW = LANE_BITS + 1;
	localparam int DW = LANES * LW;
	localparam int EW = ADDR_W + LANES + DW;

	typedef struct packed {
		logic [`SA_SYNC_W-1:0] sync;
		logic slp_lvl;
		sram_access_pkg::sleep_state_e slp_st;
		logic [`SA_SLEEP_W-1:0] slp_cnt;
		logic act;
		logic wr;
		logic [ADDR_W-1:0] base;
		logic [`SA_BURST_W-1:0] cnt;
		logic s1_v;
		logic s1_wr;
		logic [ADDR_W-1:0] s1_addr;
		logic [LANES-1:0] s1_bw;
		logic s2_v;
		logic [ADDR_W-1:0] s2_addr;
		logic [LANES-1:0] s2_bw;
		logic s3_v;
		logic [EW-1:0] s3_ent;
		logic drive;
		logic [EW-1:0] b0;
		logic [EW-1:0] b1;
		logic [`SA_BUF_W-1:0] b_cnt;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	logic cs_all;
	logic awake;
	logic buf_in_ready;
	logic buf_out_ready;
	logic buf_push;
	logic buf_pop;
	logic stall;
	logic qual;
	logic start;
	logic rd_en;
	logic [`SA_BURST_W-1:0] cnt_step;
	logic [`SA_BURST_W-1:0] low_bits;
	logic [DW-1:0] rd_word;
	logic [DW-1:0] wr_word;

	// ****************************************
	// Edge qualification
	// ****************************************
	// An edge counts only with the gate low, the part awake and no buffer stall
	assign cs_all = !chip_select_one_n && chip_select_two && !chip_select_three_n;
	assign awake = (st_r.slp_st == sram_access_pkg::SLP_AWAKE);
	assign buf_in_ready = (st_r.b_cnt != `SA_BUF_FULL);
	assign buf_out_ready = awake;
	assign buf_push = st_r.s3_v && buf_in_ready;
	assign buf_pop = (st_r.b_cnt != `SA_BUF_EMPTY) && buf_out_ready;
	assign stall = st_r.s3_v && !buf_in_ready;
	assign qual = !clock_gate_n && !stall && awake;
	assign start = qual && !advance_or_load && cs_all;

	// Burst address: add in linear order, XOR in interleaved order
	assign cnt_step = st_r.cnt + `SA_BURST_STEP;
	assign low_bits = burst_order ? (st_r.base[`SA_BURST_W-1:0] ^ cnt_step)
		: (st_r.base[`SA_BURST_W-1:0] + cnt_step);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		// Sleep pin synchroniser; a change counts once stages two and three agree
		st_nxt.sync = {st_r.sync[`SA_SYNC_W-2:0], sleep_request};
		if (st_r.sync[`SA_SYNC_W-2] == st_r.sync[`SA_SYNC_W-1]) begin
			st_nxt.slp_lvl = st_r.sync[`SA_SYNC_W-1];
		end
		// Sleep sequencer, two cycles each way
		unique case (st_r.slp_st)
			sram_access_pkg::SLP_AWAKE: begin
				st_nxt.slp_cnt = `SA_SLEEP_ZERO;
				if (st_r.slp_lvl) begin
					st_nxt.slp_st = sram_access_pkg::SLP_ENTER;
				end
			end
			sram_access_pkg::SLP_ENTER: begin
				st_nxt.slp_cnt = st_r.slp_cnt + `SA_BURST_STEP;
				if (st_r.slp_cnt + `SA_BURST_STEP == `SA_SLEEP_CYCLES) begin
					st_nxt.slp_st = sram_access_pkg::SLP_ASLEEP;
				end
			end
			sram_access_pkg::SLP_ASLEEP: begin
				st_nxt.slp_cnt = `SA_SLEEP_ZERO;
				// Accesses in stages one and two are dropped; the part wakes deselected
				st_nxt.act = 1'b0;
				st_nxt.s1_v = 1'b0;
				st_nxt.s2_v = 1'b0;
				st_nxt.drive = 1'b0;
				if (!st_r.slp_lvl) begin
					st_nxt.slp_st = sram_access_pkg::SLP_LEAVE;
				end
			end
			sram_access_pkg::SLP_LEAVE: begin
				st_nxt.slp_cnt = st_r.slp_cnt + `SA_BURST_STEP;
				if (st_r.slp_cnt + `SA_BURST_STEP == `SA_SLEEP_CYCLES) begin
					st_nxt.slp_st = sram_access_pkg::SLP_AWAKE;
				end
			end
			default: begin
				st_nxt.slp_st = sram_access_pkg::SLP_AWAKE;
			end
		endcase

		// Write stage three leaves once the buffer takes it
		if (buf_push) begin
			st_nxt.s3_v = 1'b0;
		end

		// Pipeline advances only on a qualified edge
		if (qual) begin
			if (!advance_or_load) begin
				if (cs_all) begin
					// Load: latch address and access type for the burst
					st_nxt.act = 1'b1;
					st_nxt.wr = !write_n;
					st_nxt.base = addr;
					st_nxt.cnt = `SA_BURST_ZERO;
					st_nxt.s1_v = 1'b1;
					st_nxt.s1_wr = !write_n;
					st_nxt.s1_addr = addr;
				end else begin
					st_nxt.act = 1'b0;
					st_nxt.s1_v = 1'b0;
				end
			end else begin
				// Continue: selects and strobe are not looked at
				st_nxt.cnt = cnt_step;
				st_nxt.s1_v = st_r.act;
				st_nxt.s1_wr = st_r.wr;
				st_nxt.s1_addr = {st_r.base[ADDR_W-1:`SA_BURST_W], low_bits};
			end
			// Lane enables are taken every cycle of a write burst
			st_nxt.s1_bw = ~byte_lane_write_n;
			// Data drivers follow the access issued one edge earlier
			st_nxt.drive = st_r.s1_v && !st_r.s1_wr;
			// A write with no lanes selected goes no further
			st_nxt.s2_v = st_r.s1_v && st_r.s1_wr && (|st_r.s1_bw);
			st_nxt.s2_addr = st_r.s1_addr;
			st_nxt.s2_bw = st_r.s1_bw;
			// Write data land on the second edge after issue
			st_nxt.s3_v = st_r.s2_v;
			st_nxt.s3_ent = {st_r.s2_addr, st_r.s2_bw, wr_word};
		end

		// Two-entry buffer between data capture and the array
		if (buf_pop) begin
			st_nxt.b0 = st_r.b1;
		end
		if (buf_push) begin
			if (st_r.b_cnt == `SA_BUF_EMPTY || (st_r.b_cnt == `SA_BUF_ONE && buf_pop)) begin
				st_nxt.b0 = st_r.s3_ent;
			end else begin
				st_nxt.b1 = st_r.s3_ent;
			end
		end
		st_nxt.b_cnt = st_r.b_cnt + {1'b0, buf_push} - {1'b0, buf_pop};

		// Power-up state: deselected, outputs off
		if (!rst_n) begin
			st_nxt = '0;
			st_nxt.sync = `SA_SYNC_RESET;
			st_nxt.slp_st = sram_access_pkg::SLP_AWAKE;
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		st_r <= st_nxt;
	end

	// ****************************************
	// Data path
	// ****************************************
	// Parity bit rides at the top of its byte lane
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : lane_map
			assign wr_word[g*LW +: LW] = {parity_in[g], dq_in[g*LANE_BITS +: LANE_BITS]};
			assign dq_out[g*LANE_BITS +: LANE_BITS] = rd_word[g*LW +: LANE_BITS];
			assign parity_out[g] = rd_word[g*LW + LANE_BITS];
		end
	endgenerate

	// Array read for the access issued on the previous edge
	assign rd_en = qual && st_r.s1_v && !st_r.s1_wr;

	sram_word_store #(
		.ADDR_W(ADDR_W),
		.LANES(LANES),
		.LANE_W(LW)
	) u_store (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wr_en(buf_pop),
		.wr_addr(st_r.b0[EW-1 -: ADDR_W]),
		.wr_lane(st_r.b0[DW +: LANES]),
		.wr_data(st_r.b0[DW-1:0]),
		.rd_en(rd_en),
		.rd_addr(st_r.s1_addr),
		.rd_data(rd_word)
	);

	// Output enable is asynchronous and masked by the internal drive flag
	assign dq_oe = st_r.drive && !output_enable_n && awake;
	assign sleep_active = (st_r.slp_st == sram_access_pkg::SLP_ASLEEP);

	// ****************************************
	// Checks
	// ****************************************
	a_gate_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clock_gate_n && awake) |=> ($stable(st_r.base) && $stable(st_r.cnt)
			&& $stable(st_r.s1_v) && $stable(st_r.drive)))
		else $error("State moved on a gated edge");

	a_read_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(start && write_n) ##1 qual |=> st_r.drive)
		else $error("Read data not driven after the following edge");

	a_desel_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(qual && !advance_or_load && !cs_all) ##1 qual |=> !dq_oe)
		else $error("Outputs active after deselect");

	a_write_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(start && !write_n) ##1 qual |=> !dq_oe)
		else $error("Outputs active in write data cycle");

	a_oe_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
		output_enable_n |-> !dq_oe)
		else $error("Driving with output enable high");

	a_burst_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(qual && advance_or_load) |=> (st_r.cnt == $past(st_r.cnt) + `SA_BURST_STEP))
		else $error("Burst counter did not step");

	a_type_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(qual && advance_or_load && st_r.act) |=> (st_r.s1_wr == $past(st_r.wr)))
		else $error("Access type changed inside a burst");

	a_write_commit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(start && !write_n && (|(~byte_lane_write_n))) ##1 qual ##1 qual |=> st_r.s3_v)
		else $error("Write data not captured on second edge");

	a_no_lane: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_r.s2_v |-> (|st_r.s2_bw))
		else $error("Laneless write entered the pipeline");

	a_linear_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(qual && advance_or_load && !burst_order) |=> (st_r.s1_addr[`SA_BURST_W-1:0]
			== $past(st_r.base[`SA_BURST_W-1:0]) + $past(st_r.cnt) + `SA_BURST_STEP))
		else $error("Linear burst address wrong");

	a_sleep_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!awake |-> !dq_oe)
		else $error("Outputs active while sleeping");

	a_wake_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(start && !st_r.act) |=> !st_r.drive)
		else $error("Drivers on in first clock after deselect");

	a_buf_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_r.b_cnt <= `SA_BUF_FULL)
		else $error("Write buffer count beyond two entries");

	a_reset_desel: assert property (@(posedge clk_sys)
		!rst_n |=> (!dq_oe && !st_r.act && (st_r.b_cnt == `SA_BUF_EMPTY)))
		else $error("Not deselected after reset");

endmodule : sram_pipe_access
`default_nettype wire

// >>> verification/mem_ctrl_model.sv
// Memory controller model that drives the SRAM access pins.
// Assumes one clock; pins change just after the falling edge.
`timescale 1ns/1ps
`default_nettype none

module mem_ctrl_model #(
	parameter int ADDR_W = 6
) (
	// Clock and device outputs
	input wire logic clk_sys,
	input wire logic [31:0] dq_out,
	input wire logic [3:0] parity_out,
	input wire logic dq_oe,
	// Pins toward the device
	output logic clock_gate_n,
	output logic chip_select_one_n,
	output logic chip_select_two,
	output logic chip_select_three_n,
	output logic advance_or_load,
	output logic write_n,
	output logic [3:0] byte_lane_write_n,
	output logic [ADDR_W-1:0] addr,
	output logic [31:0] dq_in,
	output logic [3:0] parity_in
);
	// *****
	// Bus level and cycle driver
	// *****
	logic drv = 1'b0;
	logic [35:0] wd = 36'h0;
	logic [35:0] last = 36'h0;

	// Shared bus: device, else controller, else a level that toggles each cycle
	always_comb begin
		if (dq_oe) {parity_in, dq_in} = {parity_out, dq_out};
		else if (drv) {parity_in, dq_in} = wd;
		else {parity_in, dq_in} = ~last;
	end

	// Remember the bus so a released bus never looks held
	always_ff @(posedge clk_sys) last <= {parity_in, dq_in};

	// Power up deselected
	initial begin
		clock_gate_n = 1'b0;
		chip_select_one_n = 1'b1;
		chip_select_two = 1'b0;
		chip_select_three_n = 1'b1;
		advance_or_load = 1'b0;
		write_n = 1'b1;
		byte_lane_write_n = 4'hf;
		addr = '0;
	end

	// One bus cycle, returning just past the rising edge
	task automatic op(input logic g_n, input logic [2:0] cs, input logic adv, input logic wn,
		input logic [3:0] bw, input logic [ADDR_W-1:0] a, input logic dv, input logic [35:0] d);
		@(negedge clk_sys);
		clock_gate_n = g_n;
		chip_select_one_n = !cs[0];
		chip_select_two = cs[1];
		chip_select_three_n = !cs[2];
		advance_or_load = adv;
		write_n = wn;
		byte_lane_write_n = bw;
		addr = a;
		drv = dv;
		wd = d;
		@(posedge clk_sys);
		#1;
	endtask : op
endmodule : mem_ctrl_model
`default_nettype wire

// >>> verification/sram_pipe_access_test.sv
// Self-checking testbench of the SRAM access logic.
// Assumes the controller model beside it and a 64-word array.
`timescale 1ns/1ps
`default_nettype none

module sram_pipe_access_test;
	// *****
	// Pins, model and checks
	// *****
	localparam int AW = 6;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic output_enable_n = 1'b0;
	logic burst_order = 1'b0;
	logic sleep_request = 1'b0;
	logic clock_gate_n, chip_select_one_n, chip_select_two, chip_select_three_n;
	logic advance_or_load, write_n, dq_oe, sleep_active;
	logic [3:0] byte_lane_write_n, parity_in, parity_out;
	logic [AW-1:0] addr;
	logic [31:0] dq_in, dq_out;
	logic [35:0] mem [64];
	int mismatches = 0;
	int checked = 0;

	always #12.5 clk_sys = ~clk_sys;

	sram_pipe_access #(.ADDR_W(AW), .LANES(4), .LANE_BITS(8)) u_sram_pipe_access (
		.clk_sys(clk_sys), .rst_n(rst_n), .clock_gate_n(clock_gate_n),
		.chip_select_one_n(chip_select_one_n), .chip_select_two(chip_select_two),
		.chip_select_three_n(chip_select_three_n), .advance_or_load(advance_or_load),
		.write_n(write_n), .byte_lane_write_n(byte_lane_write_n), .addr(addr),
		.dq_in(dq_in), .parity_in(parity_in), .dq_out(dq_out), .parity_out(parity_out),
		.dq_oe(dq_oe), .output_enable_n(output_enable_n), .burst_order(burst_order),
		.sleep_request(sleep_request), .sleep_active(sleep_active));

	mem_ctrl_model #(.ADDR_W(AW)) u_mem_ctrl_model (
		.clk_sys(clk_sys), .dq_out(dq_out), .parity_out(parity_out), .dq_oe(dq_oe),
		.clock_gate_n(clock_gate_n), .chip_select_one_n(chip_select_one_n),
		.chip_select_two(chip_select_two), .chip_select_three_n(chip_select_three_n),
		.advance_or_load(advance_or_load), .write_n(write_n),
		.byte_lane_write_n(byte_lane_write_n), .addr(addr), .dq_in(dq_in),
		.parity_in(parity_in));

	// Compare and count
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Counts and verdict
	task automatic test_done();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done

	// Address of beat k of a burst
	function automatic logic [AW-1:0] beat(input logic [AW-1:0] a, input int k);
		logic [1:0] lo;
		lo = burst_order ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
		return {a[AW-1:2], lo};
	endfunction : beat

	// Idle cycle: advance with selects off, so a deselected part stays deselected
	task automatic idle();
		u_mem_ctrl_model.op(1'b0, 3'h0, 1'b1, 1'b1, 4'hf, '0, 1'b0, 36'h0);
	endtask : idle

	// Write burst of n beats; data two edges after each issue
	task automatic burst_wr(input logic [AW-1:0] a, input int n, input logic [3:0] bw,
		input logic [35:0] s);
		logic [35:0] d;
		logic [AW-1:0] wa;
		for (int c = 0; c < n + 2; c++) begin
			d = s + 36'(c) * 36'h011111111;
			wa = beat(a, c - 2);
			u_mem_ctrl_model.op(1'b0, (c == 0) ? 3'h7 : 3'h0, c != 0 && c != n, c != 0,
				(c < n) ? bw : 4'hf, a, c >= 2, d);
			check({35'h0, dq_oe}, 36'h0);
			if (c >= 2) begin
				for (int g = 0; g < 4; g++) begin
					if (!bw[g]) begin
						mem[wa][8*g +: 8] = d[8*g +: 8];
						mem[wa][32+g] = d[32+g];
					end
				end
			end
		end
		repeat (3) idle();
	endtask : burst_wr

	// Read burst of n beats, optionally with a gated edge after the first beat
	task automatic burst_rd(input logic [AW-1:0] a, input int n, input logic gate);
		logic [35:0] q;
		for (int c = 0; c < n + 2; c++) begin
			u_mem_ctrl_model.op(1'b0, (c == 0) ? 3'h7 : 3'h0, c != 0 && c != n, c == 0,
				4'h0, a, 1'b0, 36'h0);
			if (c == 0) check({35'h0, dq_oe}, 36'h0);
			else if (c <= n) begin
				check({35'h0, dq_oe}, {35'h0, !output_enable_n});
				q = mem[beat(a, c - 1)];
				if (!output_enable_n) check({parity_out, dq_out}, q);
				if (gate && c == 1) begin
					u_mem_ctrl_model.op(1'b1, 3'h7, 1'b0, 1'b0, 4'h0, a + 1'b1, 1'b0, 36'h0);
					check({dq_oe, parity_out, dq_out}, {1'b1, q});
				end
			end else check({35'h0, dq_oe}, 36'h0);
		end
	endtask : burst_rd

	// Static pins, changed at the falling edge while idle
	task automatic pins(input logic oe_n, input logic bo, input logic zz);
		@(negedge clk_sys);
		output_enable_n = oe_n;
		burst_order = bo;
		sleep_request = zz;
	endtask : pins

	// Bounded wait for the sleep status
	task automatic wait_sleep(input logic v);
		for (int i = 0; i < 20; i++) begin
			if (sleep_active === v) return;
			idle();
		end
		mismatches++;
		$display("BAD t=%0t sleep status stuck", $time);
		test_done();
	endtask : wait_sleep

	// *****
	// Main sequence
	// *****
	initial begin
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		idle();
		check({35'h0, dq_oe}, 36'h0);
		burst_wr(6'h01, 4, 4'h0, 36'h9a5c3e170);
		burst_rd(6'h03, 4, 1'b1);
		$display("test linear done");
		pins(1'b0, 1'b1, 1'b0);
		burst_wr(6'h11, 4, 4'h0, 36'h6c1f08e2b);
		burst_rd(6'h12, 4, 1'b0);
		$display("test interleaved done");
		pins(1'b0, 1'b0, 1'b0);
		burst_wr(6'h02, 1, 4'ha, 36'hf0e1d2c3b);
		burst_wr(6'h03, 1, 4'hf, 36'h123456789);
		burst_rd(6'h00, 4, 1'b0);
		pins(1'b1, 1'b0, 1'b0);
		burst_rd(6'h00, 2, 1'b0);
		pins(1'b0, 1'b0, 1'b0);
		$display("test lanes done");
		for (int i = 0; i < 3; i++) begin
			u_mem_ctrl_model.op(1'b0, 3'h7, 1'b0, 1'b1, 4'h0, 6'h13, 1'b0, 36'h0);
			u_mem_ctrl_model.op(1'b0, 3'h7 ^ (3'h1 << i), 1'b0, 1'b1, 4'h0, 6'h13, 1'b0, 36'h0);
			check({dq_oe, parity_out, dq_out}, {1'b1, mem[6'h13]});
			idle();
			check({35'h0, dq_oe}, 36'h0);
		end
		$display("test deselect done");
		pins(1'b0, 1'b0, 1'b1);
		wait_sleep(1'b1);
		check({35'h0, dq_oe}, 36'h0);
		pins(1'b0, 1'b0, 1'b0);
		wait_sleep(1'b0);
		repeat (8) idle();
		burst_rd(6'h10, 4, 1'b0);
		$display("test sleep done");
		test_done();
	end
endmodule : sram_pipe_access_test
`default_nettype wire
